// >>> vcs_map.svh
// Register offsets, field positions, reset values and timing counts for the oscillator control block.
//
// Operation
// - Divider code 11 divides the reference-derived clock by 16 for calibration; reset default.
// - Calibration starts only on a 0-to-1 edge of the active start bit.
// - Clearing the active start bit discards the stored calibration result.
// - Sync field bits 7:6: 00 ignore, 01 asynchronous reset, 10 synchronous reset.
// - Sync field code 11 also leaves the counters untouched.
`ifndef VCS_MAP_SVH
`define VCS_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define VCS_ADDR_W        10
`define VCS_SYNC_OFS      10'h019
`define VCS_CAL_OFS       10'h018
`define VCS_UPDATE_OFS    10'h232
`define VCS_STATUS_OFS    10'h01F

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define VCS_SYNC_MSB      7
`define VCS_SYNC_LSB      6
`define VCS_DIV_MSB       2
`define VCS_DIV_LSB       1
`define VCS_START_BIT     0
`define VCS_UPDATE_BIT    0
`define VCS_SYNC_RST      8'h00
`define VCS_CAL_RST       8'h06
`define VCS_SYNC_IGNORE   2'h0
`define VCS_SYNC_ASYNC    2'h1
`define VCS_SYNC_SYNC     2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define VCS_CAL_EDGES     8'h20
`define VCS_CNT_W         8

`endif

// >>> vcs_pkg.sv
// Types shared by the oscillator control block.
package vcs_pkg;
    typedef enum logic [1:0] {VCS_IDLE, VCS_RUN, VCS_DONE} vcs_state_t;
endpackage

// >>> vcs_div_if.sv
// Interface between the control top and the calibration clock divider.
`timescale 1ns/1ps
interface vcs_div_if;
    logic [1:0] div_code;
    logic       cal_tick;
    modport ctrl (output div_code, input cal_tick);
    modport div (input div_code, output cal_tick);
endinterface

// >>> vcs_cal_div.sv
// Calibration clock divider producing a one-cycle tick per divided period.
`timescale 1ns/1ps
`include "vcs_map.svh"
module vcs_cal_div
    import vcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Divider link
    vcs_div_if.div   dv
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [3:0] last_cnt;
    logic       tick_ff;
    logic [4:0] gap_ff;
    logic       held3_ff;

    // Terminal count is 2^(code+1)-1, so code 11 gives a period of 16.
    // The shift amount is widened first, because code 11 plus one would wrap to zero in two bits.
    assign last_cnt = 4'(({1'b0, 4'h1} << ({1'b0, dv.div_code} + 3'h1)) - 5'h01);
    assign nxt_cnt  = (cnt_ff >= last_cnt) ? 4'h0 : 4'(cnt_ff + 4'h1);
    assign dv.cal_tick = tick_ff;

    // Count reference-derived cycles.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff  <= 4'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= (cnt_ff >= last_cnt);
        end
    end

    // Check helpers: cycles since the last tick, and whether code 11 held over that span.
    // A small counter keeps the period check cheap instead of a long unrolled repetition.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_ff   <= 5'h00;
            held3_ff <= 1'b0;
        end else begin
            gap_ff   <= tick_ff ? 5'h00 : ((gap_ff == 5'h1F) ? gap_ff : 5'(gap_ff + 5'h01));
            held3_ff <= (dv.div_code == 2'h3) && (tick_ff || held3_ff);
        end
    end

    chk_div_sixteen: assert property (@(posedge clk) disable iff (!rstn)
        (tick_ff && held3_ff) |-> (gap_ff == 5'h0F))
        else $error("divide-by-16 tick came early");
    chk_div_no_late: assert property (@(posedge clk) disable iff (!rstn)
        (held3_ff && gap_ff == 5'h0F) |-> tick_ff)
        else $error("divide-by-16 tick came late");
endmodule // vcs_cal_div

// >>> vcs_ctrl.sv
// Top of the oscillator calibration and counter sync control block.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "vcs_map.svh"
module vcs_ctrl
    import vcs_pkg::*;
(
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rstn,
    // Register port
    input wire logic [`VCS_ADDR_W-1:0]   reg_addr,
    input wire logic [7:0]               reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    output logic     [7:0]               reg_rdata,
    // Sync pin and counter controls
    input wire logic                     sync_n_pin,
    output logic                         cnt_async_rst,
    output logic                         cnt_sync_rst,
    // Calibration status
    output logic                         cal_busy,
    output logic                         cal_valid
);
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]  buf_sync_ff, buf_cal_ff, act_sync_ff, act_cal_ff;
    logic [7:0]  rdata_ff;
    logic        start_d_ff, sync_m_ff, sync_s_ff, sync_d_ff;
    logic        async_ff, srst_ff, busy_ff, valid_ff;
    logic [`VCS_CNT_W-1:0] edge_cnt_ff;
    vcs_state_t  state_ff, nxt_state;
    vcs_div_if   dv ();

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    wire wr_sync   = reg_wr && (reg_addr == `VCS_SYNC_OFS);
    wire wr_cal    = reg_wr && (reg_addr == `VCS_CAL_OFS);
    wire do_update = reg_wr && (reg_addr == `VCS_UPDATE_OFS) && reg_wdata[`VCS_UPDATE_BIT];
    wire act_start = act_cal_ff[`VCS_START_BIT];
    wire start_rise = act_start && !start_d_ff;
    wire [1:0] sync_mode = act_sync_ff[`VCS_SYNC_MSB:`VCS_SYNC_LSB];
    wire sync_act  = !sync_s_ff;
    wire sync_fall = sync_act && sync_d_ff;
    wire [7:0] status = {5'h00, state_ff == VCS_RUN, valid_ff, act_start};
    wire [7:0] rd_mux = (reg_addr == `VCS_SYNC_OFS)   ? buf_sync_ff :
                        (reg_addr == `VCS_CAL_OFS)    ? buf_cal_ff  :
                        (reg_addr == `VCS_STATUS_OFS) ? status      : 8'h00;
    assign dv.div_code = act_cal_ff[`VCS_DIV_MSB:`VCS_DIV_LSB];

    // Calibration divider, run from the reference clock domain.
    vcs_cal_div u_div (.clk(clk), .rstn(rstn), .dv(dv));

    // Buffered and active register sets; an update copies the whole buffer at once.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_sync_ff <= `VCS_SYNC_RST;
            buf_cal_ff  <= `VCS_CAL_RST;
            act_sync_ff <= `VCS_SYNC_RST;
            act_cal_ff  <= `VCS_CAL_RST;
        end else begin
            if (wr_sync) buf_sync_ff <= reg_wdata;
            if (wr_cal)  buf_cal_ff  <= reg_wdata;
            if (do_update) begin
                act_sync_ff <= buf_sync_ff;
                act_cal_ff  <= buf_cal_ff;
            end
        end
    end

    // Read data stands one cycle after the strobe only.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rdata_ff <= 8'h00;
        else       rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end

    // Two-flop synchroniser for the sync pin; the second stage and its one-cycle delayed copy are read.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_m_ff <= 1'b1;
            sync_s_ff <= 1'b1;
            sync_d_ff <= 1'b1;
        end else begin
            sync_m_ff <= sync_n_pin;
            sync_s_ff <= sync_m_ff;
            sync_d_ff <= sync_s_ff;
        end
    end

    // Counter resets: async mode holds reset while the pin is low, sync mode pulses once.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            async_ff <= 1'b0;
            srst_ff  <= 1'b0;
        end else begin
            async_ff <= (sync_mode == `VCS_SYNC_ASYNC) && sync_act;
            srst_ff  <= (sync_mode == `VCS_SYNC_SYNC) && sync_fall;
        end
    end

    // Calibration sequencer: runs a fixed number of calibration ticks.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            VCS_IDLE: if (start_rise) nxt_state = VCS_RUN;
            VCS_RUN: begin
                if (!act_start) nxt_state = VCS_IDLE;
                else if (dv.cal_tick && edge_cnt_ff == `VCS_CAL_EDGES - 8'h01)
                    nxt_state = VCS_DONE;
            end
            VCS_DONE: if (!act_start) nxt_state = VCS_IDLE;
            default: nxt_state = VCS_IDLE;
        endcase
    end

    // State, tick count, result and start-edge history.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff    <= VCS_IDLE;
            edge_cnt_ff <= '0;
            start_d_ff  <= 1'b0;
            valid_ff    <= 1'b0;
            busy_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            start_d_ff  <= act_start;
            busy_ff     <= (nxt_state == VCS_RUN);
            if (state_ff != VCS_RUN) edge_cnt_ff <= '0;
            else if (dv.cal_tick) edge_cnt_ff <= edge_cnt_ff + 8'h01;
            if (!act_start) valid_ff <= 1'b0;
            else if (nxt_state == VCS_DONE) valid_ff <= 1'b1;
        end
    end

    assign reg_rdata     = rdata_ff;
    assign cnt_async_rst = async_ff;
    assign cnt_sync_rst  = srst_ff;
    assign cal_busy      = busy_ff;
    assign cal_valid     = valid_ff;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_start_edge_only: assert property (@(posedge clk) disable iff (!rstn)
        (state_ff == VCS_IDLE && nxt_state == VCS_RUN) |-> (act_start && !start_d_ff))
        else $error("calibration started without rising edge");
    chk_start_runs: assert property (@(posedge clk) disable iff (!rstn)
        (state_ff == VCS_IDLE && start_rise) |=> busy_ff)
        else $error("rising edge did not start calibration");
    chk_clear_discards: assert property (@(posedge clk) disable iff (!rstn)
        !act_start |=> !valid_ff)
        else $error("result kept after start bit cleared");
    chk_async_mode: assert property (@(posedge clk) disable iff (!rstn)
        (sync_mode == `VCS_SYNC_ASYNC && sync_act) |=> async_ff)
        else $error("async reset not asserted");
    chk_sync_pulse: assert property (@(posedge clk) disable iff (!rstn)
        srst_ff |=> !srst_ff)
        else $error("sync reset longer than one cycle");
    chk_ignore_codes: assert property (@(posedge clk) disable iff (!rstn)
        (sync_mode[1] == sync_mode[0]) && $stable(sync_mode) |=> !async_ff && !srst_ff)
        else $error("counters reset in ignore mode");
    chk_update_copy: assert property (@(posedge clk) disable iff (!rstn)
        do_update |=> act_cal_ff == $past(buf_cal_ff))
        else $error("update did not copy buffer");
    chk_no_update_hold: assert property (@(posedge clk) disable iff (!rstn)
        !do_update |=> $stable(act_sync_ff) && $stable(act_cal_ff))
        else $error("active set changed without update");
endmodule // vcs_ctrl

// >>> vco_cal_and_counter_sync_bench.sv
// Self-checking testbench for the oscillator calibration and counter sync control block.
`timescale 1ns/1ps
`include "vcs_map.svh"
module vco_cal_and_counter_sync_bench;
    import vcs_pkg::*;
    logic                   clk, rstn, reg_wr, reg_rd, sync_n_pin;
    logic [`VCS_ADDR_W-1:0] reg_addr;
    logic [7:0]             reg_wdata, reg_rdata;
    logic                   cnt_async_rst, cnt_sync_rst, cal_busy, cal_valid;
    int                     errors, n_compared, n;

    vcs_ctrl uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_n_pin(sync_n_pin),
        .cnt_async_rst(cnt_async_rst), .cnt_sync_rst(cnt_sync_rst), .cal_busy(cal_busy),
        .cal_valid(cal_valid));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    // Compare a seen value against the expected one and log a mismatch.
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle write strobe.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(nm, reg_rdata, exp);
    endtask
    task automatic upd();
        wr(`VCS_UPDATE_OFS, 8'h01);
    endtask
    // Run one calibration; the busy length over 32 ticks reveals the divide ratio.
    task automatic cal(input logic [1:0] code);
        wr(`VCS_CAL_OFS, {5'h00, code, 1'b0});
        upd();
        // The clock runs from time zero, before reset is released.
        wr(`VCS_CAL_OFS, {5'h00, code, 1'b1});
        upd();
        n = 0;
        repeat (20) if (!cal_busy) @(posedge clk);
        while (cal_busy === 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check("divide", 8'((n + 16) / 32), 8'(2 << code));
        #1 check("valid", {7'h00, cal_valid}, 8'h01);
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, watchdog and verdict
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Four full calibrations and one aborted run take about 1200 cycles, so 20000 is ample.
    initial begin
        #(40 * 20000);
        errors++;
        stop_test();
    end
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        errors = 0; n_compared = 0; rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = '0; reg_wdata = 8'h00; sync_n_pin = 1'b1;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(`VCS_CAL_OFS, `VCS_CAL_RST, "cal reset");
        rd(`VCS_SYNC_OFS, 8'h00, "sync reset");
        rd(10'h3FF, 8'h00, "unmapped");
        // A buffered start must not reach the active set before the update.
        wr(`VCS_CAL_OFS, 8'h07);
        repeat (4) @(posedge clk);
        check("busy early", {7'h00, cal_busy}, 8'h00);
        rd(`VCS_STATUS_OFS, 8'h00, "status early");
        for (int c = 0; c < 4; c++) cal(2'(c));
        rd(`VCS_STATUS_OFS, 8'h03, "status done");
        // Setting an already set start bit must not start again.
        wr(`VCS_CAL_OFS, 8'h07);
        upd();
        repeat (4) @(posedge clk);
        check("no restart", {7'h00, cal_busy}, 8'h00);
        wr(`VCS_CAL_OFS, 8'h06);
        upd();
        repeat (2) @(posedge clk);
        #1 check("discard", {7'h00, cal_valid}, 8'h00);
        // Clearing the start bit in mid-run must abort the calibration at once.
        wr(`VCS_CAL_OFS, 8'h07);
        upd();
        repeat (4) @(posedge clk);
        rd(`VCS_STATUS_OFS, 8'h05, "status run");
        wr(`VCS_CAL_OFS, 8'h06);
        upd();
        repeat (2) @(posedge clk);
        #1 check("abort", {7'h00, cal_busy}, 8'h00);
        check("abort valid", {7'h00, cal_valid}, 8'h00);
        // Pin pulled low without update must still be ignored.
        wr(`VCS_SYNC_OFS, 8'h40);
        sync_n_pin <= 1'b0;
        repeat (6) @(posedge clk);
        check("no update", {7'h00, cnt_async_rst}, 8'h00);
        sync_n_pin <= 1'b1;
        repeat (6) @(posedge clk);
        // Every sync mode code with the pin held low for nine cycles.
        for (int m = 0; m < 4; m++) begin
            wr(`VCS_SYNC_OFS, 8'(m << 6));
            upd();
            rd(`VCS_SYNC_OFS, 8'(m << 6), "sync back");
            n = 0;
            @(posedge clk);
            sync_n_pin <= 1'b0;
            repeat (8) begin
                @(posedge clk);
                #1 n += cnt_sync_rst;
            end
            check("async", {7'h00, cnt_async_rst}, 8'(m == 1));
            check("sync", 8'(n), 8'(m == 2));
            @(posedge clk);
            sync_n_pin <= 1'b1;
            repeat (6) @(posedge clk);
            check("release", {7'h00, cnt_async_rst}, 8'h00);
        end
        stop_test();
    end
endmodule // vco_cal_and_counter_sync_bench
